/* logic/dio_unit.sv */
`timescale 1ns/1ps
`include "dio_params.svh"
// Devices 0 and 1 are input groups, 2 and 3 output groups.
module dio_unit #(
  parameter int W = `DIO_W
) (
  input wire logic clock, // 200 MHz system clock
  input wire logic nrst, // system reset, active low
  input wire logic por_n, // power-on reset, active low
  input wire logic cmd_valid, // command strobe
  input wire logic [1:0] cmd_dev, // addressed group device
  input wire dio_pkg::cmd_t cmd_code, // command code
  input wire logic [W-1:0] cmd_wdata, // command write data
  input wire logic [2*W-1:0] in_pts, // input points, group 1 high
  input wire logic [1:0] handshake_strobe_in, // input group sync
  input wire logic [1:0] out_strobe_in, // output group sync
  output logic rsp_valid, // answer pulse
  output logic rsp_busy, // command refused busy
  output logic [W-1:0] rsp_data, // read data
  output logic [3:0] irq_req, // interrupt request per device
  output logic [1:0] in_ready, // input group ready
  output logic [2*W-1:0] out_pts, // output points, group 3 high
  output logic [1:0] out_ready // output group ready
);
  logic [3:0] hit;
  logic [3:0] pend_q;
  logic [3:0] pend_set;
  logic [3:0] pend_clr;
  logic irq_en_q;
  logic c_prep;
  logic c_ack;
  logic c_dres;
  logic c_halt;
  logic c_rdi;
  logic c_rde;
  logic c_rdc;
  logic c_arme;
  logic c_armi;
  logic c_t1;
  logic c_t0;
  logic c_tend;
  logic c_wr;
  logic c_rdo;
  logic c_armo;
  logic c_dis;
  logic c_dsync;
  logic c_ena;
  logic [1:0] busy_in;
  logic [1:0] busy_out;
  logic [2*W-1:0] live_all;
  logic [2*W-1:0] edges_all;
  logic [2*W-1:0] outv_all;
  logic [W-1:0] rsp_data_d;
  logic busy_any;

  // Command decode
  genvar d;
  generate
    for (d = 0; d < 4; d++) begin : g_hit
      assign hit[d] = cmd_valid && (cmd_dev == 2'(d)); // see (RQ1)
    end
  endgenerate
  assign c_prep = (cmd_code == dio_pkg::prepare_cmd);
  assign c_ack = (cmd_code == dio_pkg::int_ack_cmd);
  assign c_dres = (cmd_code == dio_pkg::dev_reset_cmd);
  assign c_halt = (cmd_code == dio_pkg::halt_io_cmd);
  assign c_rdi = (cmd_code == dio_pkg::read_inputs_cmd);
  assign c_rde = (cmd_code == dio_pkg::read_edges_cmd);
  assign c_rdc = (cmd_code == dio_pkg::read_edges_and_clear_cmd);
  assign c_arme = (cmd_code == dio_pkg::arm_edge_interrupt_cmd);
  assign c_armi = (cmd_code == dio_pkg::arm_input_handshake_cmd);
  assign c_t1 = (cmd_code == dio_pkg::test_ones_cmd);
  assign c_t0 = (cmd_code == dio_pkg::test_zeros_cmd);
  assign c_tend = (cmd_code == dio_pkg::test_end_cmd);
  assign c_wr = (cmd_code == dio_pkg::write_out_cmd);
  assign c_rdo = (cmd_code == dio_pkg::read_out_cmd);
  assign c_armo = (cmd_code == dio_pkg::arm_out_handshake_cmd);
  assign c_dis = (cmd_code == dio_pkg::disable_out_cmd);
  assign c_dsync = (cmd_code == dio_pkg::diag_sync_cmd);
  assign c_ena = (cmd_code == dio_pkg::enable_out_cmd);

  // Input groups
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_in
      logic sel, busy, cancel_hs, clr_edge, freeze;
      logic [W-1:0] pins, eff, rise;
      logic strobe_eff, strobe_rise, or_now;
      logic diag_q, diag_val_q, or_prev_q, edge_mode_q;
      logic [1:0] pstep_q;
      logic [W-1:0] live_q, edges_q;
      dio_pkg::ihs_t ihs_q;

      assign sel = hit[g];
      assign pins = in_pts[g*W +: W];
      assign busy = sel && (c_t1 || c_t0) && pend_q[g]; // see (RQ22)
      assign busy_in[g] = busy;
      // Diagnostic data replaces the pins; strobe pulses low then high
      assign eff = diag_q ? {W{diag_val_q}} : pins; // see (RQ8)
      assign strobe_eff = diag_q ? pstep_q[`DIO_PSTEP_HIGH_BIT]
                                 : handshake_strobe_in[g]; // see (RQ8)
      assign cancel_hs = sel && (c_arme || c_dres || c_halt); // see (RQ13)
      assign clr_edge = sel && (c_rdc || c_arme || c_dres); // see (RQ5)
      // Held from the strobe edge until the read frees it
      assign freeze = (sel && c_rdi) || (ihs_q == dio_pkg::ihs_held)
        || ((ihs_q == dio_pkg::ihs_ready) && strobe_rise); // see (RQ3)
      assign or_now = |edges_q;

      edge_detect #(.W(W)) u_pin_edge (
        .clock(clock),
        .nrst(nrst),
        .por_n(por_n),
        .lvl(eff),
        .rise(rise),
        .fall()
      );
      edge_detect #(.W(1)) u_strobe_edge (
        .clock(clock),
        .nrst(nrst),
        .por_n(por_n),
        .lvl(strobe_eff),
        .rise(strobe_rise),
        .fall()
      );

      always_ff @(posedge clock or negedge nrst or negedge por_n) begin
        if (!nrst || !por_n) begin
          diag_q <= 1'b0;
          diag_val_q <= 1'b0;
          pstep_q <= `DIO_PSTEP_IDLE;
        end else if (sel && (c_t1 || c_t0) && !busy) begin
          diag_q <= 1'b1; // see (RQ8)
          diag_val_q <= c_t1;
          pstep_q <= `DIO_PSTEP_START;
        end else begin
          if (sel && (c_tend || c_dres)) begin
            diag_q <= 1'b0;
          end
          pstep_q <= {pstep_q[0], 1'b0};
        end
      end

      always_ff @(posedge clock or negedge nrst or negedge por_n) begin
        if (!nrst || !por_n) begin
          live_q <= '0;
        end else if (!freeze) begin
          live_q <= eff; // see (RQ3)
        end
      end

      // A new rise wins over a clear in the same cycle
      always_ff @(posedge clock or negedge nrst or negedge por_n) begin
        if (!nrst || !por_n) begin
          edges_q <= '0; // see (RQ5)
        end else begin
          edges_q <= (clr_edge ? '0 : edges_q) | rise; // see (RQ4)
        end
      end

      // Interrupt on the OR turning on, so a plain read after the
      // acknowledge raises nothing new
      always_ff @(posedge clock or negedge nrst or negedge por_n) begin
        if (!nrst || !por_n) begin
          edge_mode_q <= 1'b0; // see (RQ7)
          or_prev_q <= 1'b0;
        end else begin
          // A clear that meets a rise must still let the rise interrupt
          or_prev_q <= clr_edge ? 1'b0 : or_now; // see (RQ24)
          if (sel && c_arme) begin
            edge_mode_q <= 1'b1;
          end else if (sel && (c_dres || c_halt)) begin
            edge_mode_q <= 1'b0; // see (RQ7)
          end
        end
      end

      always_ff @(posedge clock or negedge nrst or negedge por_n) begin
        if (!nrst || !por_n) begin
          ihs_q <= dio_pkg::ihs_off; // see (RQ13)
        end else begin
          case (ihs_q)
            dio_pkg::ihs_off: begin
              if (sel && c_armi) begin
                ihs_q <= dio_pkg::ihs_ready; // see (RQ9)
              end
            end
            dio_pkg::ihs_ready: begin
              if (cancel_hs) ihs_q <= dio_pkg::ihs_off;
              else if (strobe_rise) ihs_q <= dio_pkg::ihs_held; // see (RQ11)
            end
            dio_pkg::ihs_held: begin
              if (cancel_hs) ihs_q <= dio_pkg::ihs_off;
              else if (sel && c_rdi) begin
                ihs_q <= dio_pkg::ihs_ready; // see (RQ11)
              end
            end
            default: ihs_q <= dio_pkg::ihs_off;
          endcase
        end
      end

      assign pend_set[g] = (edge_mode_q && or_now && !or_prev_q) // see (RQ6)
        || ((ihs_q == dio_pkg::ihs_ready) && strobe_rise && !cancel_hs); // see (RQ12)
      assign live_all[g*W +: W] = live_q;
      assign edges_all[g*W +: W] = edges_q;

      always_ff @(posedge clock or negedge nrst or negedge por_n) begin
        if (!nrst || !por_n) begin
          in_ready[g] <= 1'b0;
        end else begin
          in_ready[g] <= (ihs_q == dio_pkg::ihs_ready) && !strobe_rise
            && !cancel_hs; // see (RQ9)
        end
      end
    end
  endgenerate

  // Output groups
  generate
    for (g = 0; g < 2; g++) begin : g_out
      logic sel, busy, diag_cmd, armed, rdy, irq_ev, s_fall;
      logic sync_eff;
      logic dis_q, diag_q;
      logic [1:0] pstep_q;
      logic [W-1:0] val_q;

      assign sel = hit[g + 2];
      assign busy = sel && (c_dis || c_dsync) && pend_q[g + 2]; // see (RQ22)
      assign busy_out[g] = busy;
      assign diag_cmd = sel && c_dsync && !busy;
      assign sync_eff = diag_q ? pstep_q[`DIO_PSTEP_HIGH_BIT]
                               : out_strobe_in[g]; // see (RQ16)

      edge_detect #(.W(1)) u_sync_edge (
        .clock(clock),
        .nrst(nrst),
        .por_n(por_n),
        .lvl(sync_eff),
        .rise(),
        .fall(s_fall)
      );
      out_hs_fsm u_hs (
        .clock(clock),
        .nrst(nrst),
        .por_n(por_n),
        .arm(sel && c_armo),
        .cancel(sel && (c_dres || c_halt)), // see (RQ20)
        .wrote(sel && c_wr),
        .sync_lvl(sync_eff),
        .sync_fall(s_fall),
        .armed(armed),
        .ready(rdy),
        .irq_set(irq_ev)
      );

      // Only power-on clears the stored output word
      always_ff @(posedge clock or negedge por_n) begin
        if (!por_n) begin
          val_q <= '0; // see (RQ14)
        end else if (sel && c_wr) begin
          val_q <= cmd_wdata; // see (RQ15)
        end
      end

      always_ff @(posedge clock or negedge nrst or negedge por_n) begin
        if (!nrst || !por_n) begin
          dis_q <= 1'b0;
          diag_q <= 1'b0;
          pstep_q <= `DIO_PSTEP_IDLE;
        end else if (diag_cmd) begin
          dis_q <= 1'b1; // see (RQ16)
          diag_q <= 1'b1;
          pstep_q <= `DIO_PSTEP_START;
        end else begin
          if (sel && c_dis && !busy) begin
            dis_q <= 1'b1; // see (RQ16)
          end
          if (sel && (c_ena || c_dres)) begin
            dis_q <= 1'b0; // see (RQ23)
            diag_q <= 1'b0;
          end
          pstep_q <= {pstep_q[0], 1'b0};
        end
      end

      assign pend_set[g + 2] = irq_ev
        || (diag_cmd && dis_q && armed); // see (RQ21)
      assign outv_all[g*W +: W] = val_q;

      always_ff @(posedge clock or negedge nrst or negedge por_n) begin
        if (!nrst || !por_n) begin
          out_pts[g*W +: W] <= '0;
          out_ready[g] <= 1'b0;
        end else begin
          out_pts[g*W +: W] <= dis_q ? '0 : val_q; // see (RQ15)
          out_ready[g] <= rdy && !dis_q; // see (RQ17)
        end
      end
    end
  endgenerate

  // Pending interrupts: a new event wins over the acknowledge
  generate
    for (d = 0; d < 4; d++) begin : g_clr
      assign pend_clr[d] = hit[d] && (c_ack || c_dres);
    end
  endgenerate

  always_ff @(posedge clock or negedge nrst or negedge por_n) begin
    if (!nrst || !por_n) begin
      pend_q <= '0;
      irq_en_q <= 1'b0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | pend_set;
      if (cmd_valid && c_prep) begin
        irq_en_q <= cmd_wdata[`DIO_PREP_EN_BIT]; // see (RQ2)
      end
    end
  end

  // Answer path
  assign busy_any = |{busy_in, busy_out};
  assign rsp_data_d =
      (cmd_dev[`DIO_DEV_OUT_BIT] && c_rdo) ? outv_all[cmd_dev[0]*W +: W]
    : (!cmd_dev[`DIO_DEV_OUT_BIT] && c_rdi) ? live_all[cmd_dev[0]*W +: W]
    : (!cmd_dev[`DIO_DEV_OUT_BIT] && (c_rde || c_rdc))
      ? edges_all[cmd_dev[0]*W +: W] // see (RQ24)
    : '0;

  always_ff @(posedge clock or negedge nrst or negedge por_n) begin
    if (!nrst || !por_n) begin
      rsp_valid <= 1'b0;
      rsp_busy <= 1'b0;
      rsp_data <= '0;
      irq_req <= '0;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_busy <= busy_any;
      rsp_data <= cmd_valid ? rsp_data_d : '0;
      irq_req <= irq_en_q ? ((pend_q & ~pend_clr) | pend_set) : '0; // see (RQ2)
    end
  end
endmodule // dio_unit

/* inc/dio_params.svh */
// Overview of operation
// (RQ1) Two input, two output groups, own addresses
// (RQ2) One prepare command enables all four interrupts
// (RQ3) Live input register tracks pins unless frozen
// (RQ4) Edge latch bit sets on first rise
// (RQ5) Edge latch cleared only by listed commands/resets
// (RQ6) Armed edge mode interrupts on OR of latch
// (RQ7) Edge mode cancelled by reset, halt, resets
// (RQ8) Test ones/zeros force inputs and pulse strobe
// (RQ9) Input handshake arm raises ready
// (RQ10) User sets data stable before strobe
// (RQ11) Strobe rise holds data, interrupts, drops ready
// (RQ12) Next input interrupt needs new strobe rise
// (RQ13) Input handshake cancelled by arm-edge, reset, halt
// (RQ14) Output register written by write, cleared by power-on
// (RQ15) Output bits hold until next write; readback harmless
// (RQ16) Disable and diagnostic-sync turn outputs off
// (RQ17) Output handshake: ready after write+sync, interrupt on fall
// (RQ18) User raises sync when ready, drops when taken
// (RQ19) Next output ready needs write and sync again
// (RQ20) Output handshake cancelled by reset, halt, resets
// (RQ21) Diag sync after disable in handshake interrupts
// (RQ22) Diagnostic commands busy while interrupt pending
// (RQ23) Leaving diagnostic restores outputs and inputs
// (RQ24) Plain edge read neither clears nor re-interrupts
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH
`define DIO_W 16
`define DIO_DEV_OUT_BIT 1
`define DIO_PREP_EN_BIT 0
`define DIO_PSTEP_START 2'h1
`define DIO_PSTEP_IDLE 2'h0
`define DIO_PSTEP_HIGH_BIT 1
`endif

/* inc/dio_pkg.sv */
package dio_pkg;
  typedef enum logic [4:0] {
    prepare_cmd = 5'h00,
    int_ack_cmd = 5'h01,
    dev_reset_cmd = 5'h02,
    halt_io_cmd = 5'h03,
    read_inputs_cmd = 5'h04,
    read_edges_cmd = 5'h05,
    read_edges_and_clear_cmd = 5'h06,
    arm_edge_interrupt_cmd = 5'h07,
    arm_input_handshake_cmd = 5'h08,
    test_ones_cmd = 5'h09,
    test_zeros_cmd = 5'h0a,
    test_end_cmd = 5'h0b,
    write_out_cmd = 5'h0c,
    read_out_cmd = 5'h0d,
    arm_out_handshake_cmd = 5'h0e,
    disable_out_cmd = 5'h0f,
    diag_sync_cmd = 5'h10,
    enable_out_cmd = 5'h11
  } cmd_t;
  typedef enum logic [2:0] {
    ihs_off = 3'h1,
    ihs_ready = 3'h2,
    ihs_held = 3'h4
  } ihs_t;
  typedef enum logic [3:0] {
    ohs_off = 4'h1,
    ohs_wait_write = 4'h2,
    ohs_wait_sync = 4'h4,
    ohs_ready = 4'h8
  } ohs_t;
endpackage

/* logic/edge_detect.sv */
`timescale 1ns/1ps
// Previous value resets to ones so a pin already high at reset is
// not mistaken for a fresh rise.
module edge_detect #(
  parameter int W = 1
) (
  input wire logic clock, // system clock
  input wire logic nrst, // system reset, active low
  input wire logic por_n, // power-on reset, active low
  input wire logic [W-1:0] lvl, // sampled level
  output logic [W-1:0] rise, // 0 to 1 this cycle
  output logic [W-1:0] fall // 1 to 0 this cycle
);
  logic [W-1:0] prev_q;
  always_ff @(posedge clock or negedge nrst or negedge por_n) begin
    if (!nrst || !por_n) begin
      prev_q <= '1;
    end else begin
      prev_q <= lvl;
    end
  end
  assign rise = lvl & ~prev_q;
  assign fall = ~lvl & prev_q;
endmodule // edge_detect

/* logic/out_hs_fsm.sv */
`timescale 1ns/1ps
module out_hs_fsm (
  input wire logic clock, // system clock
  input wire logic nrst, // system reset, active low
  input wire logic por_n, // power-on reset, active low
  input wire logic arm, // arm output handshake
  input wire logic cancel, // device reset or halt
  input wire logic wrote, // write-output accepted
  input wire logic sync_lvl, // effective sync level
  input wire logic sync_fall, // effective sync 1 to 0
  output logic armed, // handshake mode active
  output logic ready, // ready level to drive
  output logic irq_set // one-cycle interrupt event
);
  dio_pkg::ohs_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    irq_set = 1'b0;
    case (st_q)
      dio_pkg::ohs_off: begin
        if (arm) st_d = dio_pkg::ohs_wait_write;
      end
      dio_pkg::ohs_wait_write: begin
        if (wrote) st_d = dio_pkg::ohs_wait_sync; // see (RQ19)
      end
      dio_pkg::ohs_wait_sync: begin
        if (sync_lvl) st_d = dio_pkg::ohs_ready; // see (RQ17)
      end
      dio_pkg::ohs_ready: begin
        if (sync_fall) begin
          st_d = dio_pkg::ohs_wait_write; // see (RQ17)
          irq_set = 1'b1; // see (RQ19)
        end
      end
      default: st_d = dio_pkg::ohs_off;
    endcase
    if (cancel) begin
      st_d = dio_pkg::ohs_off; // see (RQ20)
    end
  end
  always_ff @(posedge clock or negedge nrst or negedge por_n) begin
    if (!nrst || !por_n) begin
      st_q <= dio_pkg::ohs_off; // see (RQ20)
    end else begin
      st_q <= st_d;
    end
  end
  assign armed = (st_q != dio_pkg::ohs_off);
  assign ready = (st_d == dio_pkg::ohs_ready);
endmodule // out_hs_fsm

/* sim/dio_unit_asserts.sv */
`timescale 1ns/1ps
module dio_unit_asserts #(
  parameter int W = 16
) (
  input wire logic clock, // system clock
  input wire logic nrst, // system reset
  input wire logic por_n, // power-on reset
  input wire logic cmd_valid, // command strobe
  input wire logic [1:0] cmd_dev, // device
  input wire dio_pkg::cmd_t cmd_code, // command
  input wire logic [W-1:0] cmd_wdata, // write data
  input wire logic [2*W-1:0] in_pts, // input points
  input wire logic [1:0] handshake_strobe_in, // input sync
  input wire logic [1:0] out_strobe_in, // output sync
  input wire logic rsp_valid, // answer
  input wire logic rsp_busy, // refused
  input wire logic [W-1:0] rsp_data, // read data
  input wire logic [3:0] irq_req, // interrupts
  input wire logic [1:0] in_ready, // input ready
  input wire logic [2*W-1:0] out_pts, // output points
  input wire logic [1:0] out_ready // output ready
);
  logic prep_q;
  logic prep_d;
  // Shadow of the presentation enable, so irq checks know when to expect
  assign prep_d = (cmd_valid && cmd_code == dio_pkg::prepare_cmd) ?
    cmd_wdata[0] : prep_q;
  always_ff @(posedge clock or negedge nrst or negedge por_n) begin
    if (!nrst || !por_n) prep_q <= 1'b0;
    else prep_q <= prep_d;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst || !por_n);
  AST_RSP_NEXT: assert property (cmd_valid |=> rsp_valid)
    else $error("no answer one cycle after a command");
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without a command");
  AST_BUSY_DIAG: assert property (rsp_busy |-> rsp_valid &&
    $past(cmd_code) inside {dio_pkg::test_ones_cmd, dio_pkg::test_zeros_cmd,
    dio_pkg::disable_out_cmd, dio_pkg::diag_sync_cmd})
    else $error("busy on a non-diagnostic command");
  AST_OUT_WRITE: assert property (cmd_valid &&
    cmd_code == dio_pkg::write_out_cmd && cmd_dev == 2'h2
    |-> ##2 out_pts[W-1:0] == $past(cmd_wdata, 2))
    else $error("written word not on outputs");
  AST_IN_READY_DROP: assert property (
    $rose(handshake_strobe_in[0]) && in_ready[0] |-> ##[1:2] !in_ready[0])
    else $error("input ready kept after strobe");
  AST_IN_IRQ: assert property ($rose(handshake_strobe_in[0]) &&
    in_ready[0] && prep_q |-> ##[1:3] irq_req[0])
    else $error("no interrupt after input strobe");
  AST_OUT_DROP: assert property ($fell(out_strobe_in[0]) &&
    out_ready[0] && prep_q |-> ##[1:3] (irq_req[2] && !out_ready[0]))
    else $error("output sync release not answered");
  AST_OUT_READY_SYNC: assert property ($rose(out_ready[0]) |->
    out_strobe_in[0] || $past(out_strobe_in[0]))
    else $error("output ready without sync");
  AST_IRQ_PREP: assert property (|irq_req |-> prep_q || $past(prep_q))
    else $error("interrupt while not prepared");
  cover property (irq_req[0]);
  cover property ($fell(out_ready[0]));
  cover property (rsp_busy);
endmodule // dio_unit_asserts

bind dio_unit dio_unit_asserts #(.W(W)) i_asserts (.clock(clock),
  .nrst(nrst), .por_n(por_n), .cmd_valid(cmd_valid), .cmd_dev(cmd_dev),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .in_pts(in_pts),
  .handshake_strobe_in(handshake_strobe_in), .out_strobe_in(out_strobe_in),
  .rsp_valid(rsp_valid), .rsp_busy(rsp_busy), .rsp_data(rsp_data),
  .irq_req(irq_req), .in_ready(in_ready), .out_pts(out_pts),
  .out_ready(out_ready));

/* sim/user_equip.sv */
`timescale 1ns/1ps
module user_equip (
  input wire logic clock, // system clock
  input wire logic nrst, // reset, active low
  input wire logic [31:0] lvl, // wanted input levels
  input wire logic in_req, // send one handshake word
  input wire logic out_req, // take one output word
  input wire logic [1:0] in_ready, // input ready
  input wire logic [1:0] out_ready, // output ready
  input wire logic [31:0] out_pts, // output points
  output logic [31:0] in_pts, // input points
  output logic [1:0] handshake_strobe_in, // input sync
  output logic [1:0] out_strobe_in, // output sync
  output logic [15:0] got_word, // word taken
  output logic got_done // word taken flag
);
  logic [1:0] ist_q;
  assign in_pts = lvl;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ist_q <= 2'h0;
      handshake_strobe_in <= 2'h0;
      out_strobe_in <= 2'h0;
      got_word <= 16'h0000;
      got_done <= 1'b0;
    end else begin
      case (ist_q)
        2'h0: if (in_req) ist_q <= 2'h1;
        // One settled cycle of data before the strobe
        2'h1: begin
          handshake_strobe_in <= 2'h1;
          ist_q <= 2'h2;
        end
        default: if (!in_ready[0]) begin
          handshake_strobe_in <= 2'h0;
          ist_q <= 2'h0;
        end
      endcase
      if (out_req) begin
        out_strobe_in <= 2'h1;
        got_done <= 1'b0;
      end else if (out_strobe_in[0] && out_ready[0]) begin
        got_word <= out_pts[15:0];
        got_done <= 1'b1;
        out_strobe_in <= 2'h0;
      end
    end
  end
endmodule // user_equip

/* sim/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module testbench;
  typedef struct {
    logic [1:0] dev;
    dio_pkg::cmd_t code;
    logic [15:0] wd;
    logic [15:0] exp;
  } row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic por_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_dev = 2'h0;
  dio_pkg::cmd_t cmd_code = dio_pkg::prepare_cmd;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [31:0] lvl = 32'h1234_00f0;
  logic in_req = 1'b0;
  logic out_req = 1'b0;
  logic [31:0] in_pts, out_pts;
  logic [1:0] hs_in, os_in, in_ready, out_ready;
  logic rsp_valid, rsp_busy, got_done;
  logic [15:0] rsp_data, got_word, rdata;
  logic [3:0] irq_req;
  logic rbusy;
  logic [3:0] flg;
  int err_count = 0;
  int total_checks = 0;
  row_t rows [8];
  assign flg = {got_done, in_ready[0], irq_req[2], irq_req[0]};
  always #2.5 clock = ~clock;
  dio_unit #(.W(16)) i_dut (.clock(clock), .nrst(nrst), .por_n(por_n),
    .cmd_valid(cmd_valid), .cmd_dev(cmd_dev), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .in_pts(in_pts), .handshake_strobe_in(hs_in),
    .out_strobe_in(os_in), .rsp_valid(rsp_valid), .rsp_busy(rsp_busy),
    .rsp_data(rsp_data), .irq_req(irq_req), .in_ready(in_ready),
    .out_pts(out_pts), .out_ready(out_ready));
  user_equip i_user (.clock(clock), .nrst(nrst), .lvl(lvl),
    .in_req(in_req), .out_req(out_req), .in_ready(in_ready),
    .out_ready(out_ready), .out_pts(out_pts), .in_pts(in_pts),
    .handshake_strobe_in(hs_in), .out_strobe_in(os_in),
    .got_word(got_word), .got_done(got_done));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (e !== g) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait on one of the watched flags
  task automatic wait_flag(input int i, input logic v);
    for (int n = 0; n < 50; n++) begin
      @(negedge clock);
      if (flg[i] === v) return;
    end
    err_count++;
    $display("FAIL wait flag %0d expected %h seen %h", i, v, flg[i]);
    print_verdict();
  endtask
  task automatic cmd(input logic [1:0] d, input dio_pkg::cmd_t c,
                     input logic [15:0] w);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_dev <= d;
    cmd_code <= c;
    cmd_wdata <= w;
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      @(negedge clock);
      if (rsp_valid === 1'b1) begin
        rdata = rsp_data;
        rbusy = rsp_busy;
        return;
      end
    end
    err_count++;
    $display("FAIL answer expected 1 seen %h", rsp_valid);
    print_verdict();
  endtask
  task automatic pulse_req(input logic o);
    @(posedge clock);
    if (o) out_req <= 1'b1;
    else in_req <= 1'b1;
    @(posedge clock);
    out_req <= 1'b0;
    in_req <= 1'b0;
  endtask
  initial begin
    rows[0] = '{2'h2, dio_pkg::write_out_cmd, 16'ha5a5, 16'h0000};
    rows[1] = '{2'h3, dio_pkg::write_out_cmd, 16'h5a5a, 16'h0000};
    rows[2] = '{2'h2, dio_pkg::read_out_cmd, 16'h0000, 16'ha5a5};
    rows[3] = '{2'h3, dio_pkg::read_out_cmd, 16'h0000, 16'h5a5a};
    rows[4] = '{2'h0, dio_pkg::read_inputs_cmd, 16'h0000, 16'h00f0};
    rows[5] = '{2'h1, dio_pkg::read_inputs_cmd, 16'h0000, 16'h1234};
    rows[6] = '{2'h0, dio_pkg::read_edges_cmd, 16'h0000, 16'h0000};
    rows[7] = '{2'h2, dio_pkg::read_inputs_cmd, 16'h0000, 16'h0000};
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    por_n <= 1'b1;
    foreach (rows[i]) begin
      cmd(rows[i].dev, rows[i].code, rows[i].wd);
      `CHK("row data", rows[i].exp, rdata);
    end
    `CHK("outputs", 32'h5a5a_a5a5, out_pts);
    cmd(2'h1, dio_pkg::test_ones_cmd, 16'h0000);
    `CHK("test busy", 1'b0, rbusy);
    cmd(2'h1, dio_pkg::read_inputs_cmd, 16'h0000);
    `CHK("forced ones", 16'hffff, rdata);
    cmd(2'h1, dio_pkg::read_edges_cmd, 16'h0000);
    `CHK("forced edges", 16'hedcb, rdata);
    cmd(2'h1, dio_pkg::test_zeros_cmd, 16'h0000);
    cmd(2'h1, dio_pkg::read_inputs_cmd, 16'h0000);
    `CHK("forced zeros", 16'h0000, rdata);
    cmd(2'h1, dio_pkg::test_end_cmd, 16'h0000);
    cmd(2'h1, dio_pkg::read_inputs_cmd, 16'h0000);
    `CHK("inputs back", 16'h1234, rdata);
    cmd(2'h0, dio_pkg::prepare_cmd, 16'h0001);
    cmd(2'h0, dio_pkg::arm_edge_interrupt_cmd, 16'h0000);
    @(posedge clock);
    lvl[0] <= 1'b1;
    wait_flag(0, 1'b1);
    cmd(2'h0, dio_pkg::test_ones_cmd, 16'h0000);
    `CHK("busy", 1'b1, rbusy);
    cmd(2'h0, dio_pkg::read_edges_cmd, 16'h0000);
    `CHK("edges", 16'h0001, rdata);
    cmd(2'h0, dio_pkg::int_ack_cmd, 16'h0000);
    cmd(2'h0, dio_pkg::read_edges_cmd, 16'h0000);
    `CHK("edges kept", 16'h0001, rdata);
    `CHK("no new irq", 1'b0, irq_req[0]);
    cmd(2'h0, dio_pkg::read_edges_and_clear_cmd, 16'h0000);
    `CHK("edges read", 16'h0001, rdata);
    cmd(2'h0, dio_pkg::read_edges_cmd, 16'h0000);
    `CHK("edges cleared", 16'h0000, rdata);
    cmd(2'h0, dio_pkg::dev_reset_cmd, 16'h0000);
    @(posedge clock);
    lvl[2] <= 1'b1;
    repeat (4) @(negedge clock);
    `CHK("edge irq off", 1'b0, irq_req[0]);
    cmd(2'h0, dio_pkg::arm_input_handshake_cmd, 16'h0000);
    wait_flag(2, 1'b1);
    @(posedge clock);
    lvl[15:0] <= 16'hbeef;
    pulse_req(1'b0);
    wait_flag(0, 1'b1);
    @(posedge clock);
    lvl[15:0] <= 16'h0000;
    cmd(2'h0, dio_pkg::read_inputs_cmd, 16'h0000);
    `CHK("held word", 16'hbeef, rdata);
    wait_flag(2, 1'b1);
    cmd(2'h0, dio_pkg::int_ack_cmd, 16'h0000);
    cmd(2'h0, dio_pkg::halt_io_cmd, 16'h0000);
    `CHK("halted ready", 1'b0, in_ready[0]);
    cmd(2'h2, dio_pkg::arm_out_handshake_cmd, 16'h0000);
    cmd(2'h2, dio_pkg::write_out_cmd, 16'h3c3c);
    pulse_req(1'b1);
    wait_flag(3, 1'b1);
    wait_flag(1, 1'b1);
    `CHK("taken word", 16'h3c3c, got_word);
    `CHK("out ready", 1'b0, out_ready[0]);
    cmd(2'h2, dio_pkg::int_ack_cmd, 16'h0000);
    cmd(2'h2, dio_pkg::disable_out_cmd, 16'h0000);
    repeat (2) @(negedge clock);
    `CHK("disabled", 16'h0000, out_pts[15:0]);
    cmd(2'h2, dio_pkg::diag_sync_cmd, 16'h0000);
    `CHK("diag irq", 1'b1, irq_req[2]);
    cmd(2'h2, dio_pkg::diag_sync_cmd, 16'h0000);
    `CHK("diag busy", 1'b1, rbusy);
    cmd(2'h2, dio_pkg::int_ack_cmd, 16'h0000);
    cmd(2'h2, dio_pkg::enable_out_cmd, 16'h0000);
    repeat (2) @(negedge clock);
    `CHK("restored", 16'h3c3c, out_pts[15:0]);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    cmd(2'h3, dio_pkg::read_out_cmd, 16'h0000);
    `CHK("kept by reset", 16'h5a5a, rdata);
    @(posedge clock);
    por_n <= 1'b0;
    repeat (2) @(posedge clock);
    por_n <= 1'b1;
    cmd(2'h3, dio_pkg::read_out_cmd, 16'h0000);
    `CHK("power-on clear", 16'h0000, rdata);
    print_verdict();
  end
endmodule // testbench
